// ===== core/mbtb_pkg.sv
// constants for the branch, transfer and bit-operation core
// assumes a single 20 MHz clock and synchronous reset
package mbtb_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] PC_OFS = 8'h08;
	localparam logic [7:0] SP_OFS = 8'h0C;
	// control field and reset values
	localparam int CTRL_RUN_BIT = 0;
	localparam logic CTRL_RUN_RESET = 1'b1;
	localparam logic [15:0] SP_RESET = 16'h025F;
	// status register flag positions
	localparam int FLG_C = 0;
	localparam int FLG_Z = 1;
	localparam int FLG_N = 2;
	localparam int FLG_V = 3;
	localparam int FLG_S = 4;
	localparam int FLG_H = 5;
	localparam int FLG_T = 6;
	localparam int FLG_I = 7;
	localparam logic [2:0] SIGNED_FLAG_SEL = 3'h4;
	// low registers of the pointer pairs
	localparam logic [4:0] PTR_X_LO = 5'h1A;
	localparam logic [4:0] PTR_Y_LO = 5'h1C;
	localparam logic [4:0] PTR_Z_LO = 5'h1E;
	typedef enum logic [2:0] {
		ST_EXEC = 3'b000,
		ST_STALL = 3'b001,
		ST_WORD2 = 3'b010,
		ST_LPM1 = 3'b011,
		ST_LPM2 = 3'b100,
		ST_IOBIT = 3'b101
	} mbtb_state_e;
	typedef struct packed {
		mbtb_state_e state;
		logic [31:0][7:0] rf;
		logic [7:0] status_register;
		logic [15:0] pc;
		logic [15:0] sp;
		logic run;
		logic [15:0] pm_addr;
		logic [15:0] dm_addr;
		logic [7:0] dm_wdata;
		logic dm_we;
		logic dm_re;
		logic [5:0] io_addr;
		logic [7:0] io_wdata;
		logic io_we;
		logic io_re;
		logic wb_pend;
		logic wb_io;
		logic [4:0] wb_reg;
		logic [4:0] tmp_reg;
		logic tmp_flag;
		logic [2:0] tmp_bit;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} mbtb_regs_s;
endpackage

// ===== core/mbtb_core.sv
// execution core for branches, data transfer and bit operations
// assumes memories answer combinationally to the registered addresses
// Behaviour
// - signed ge/lt branch on N xor V; target PC+k+1; 1 or 2 cycles
// - half-carry branches taken on H set or clear; 1 or 2 cycles
// - transfer-bit branches taken on T set or clear; flags unchanged
// - overflow branches taken on V set or clear; flags unchanged
// - interrupt branches taken on I set or clear; target PC+k+1
// - post-increment load reads at pointer then bumps pointer; 2 cycles
// - pre-decrement load lowers pointer then reads; 2 cycles
// - displaced load reads Y or Z plus q, pointer kept; 2 cycles
// - stores: plain, post-inc, pre-dec or displaced; 2 cycles each
// - direct load and store use address word in instruction; 2 cycles
// - program memory read at Z into r0 or Rd, optional Z+; 3 cycles
// - push and pop move a register via stack; 2 cycles, no flags
// - io bit set/clear forces one io bit; 2 cycles, no flags
// - rotates through carry, update Z C N V S in 1 cycle
// - bit store to T and bit load from T, 1 cycle each
// - each flag set/clear forces only its own flag in 1 cycle
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
module mbtb_core #(
	parameter logic [15:0] SP_INIT = mbtb_pkg::SP_RESET
)(
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [15:0] pm_addr,
	input wire logic [15:0] pm_rdata,
	output logic [15:0] dm_addr,
	output logic [7:0] dm_wdata,
	output logic dm_we,
	output logic dm_re,
	input wire logic [7:0] dm_rdata,
	output logic [5:0] io_addr,
	output logic [7:0] io_wdata,
	output logic io_we,
	output logic io_re,
	input wire logic [7:0] io_rdata
);
	mbtb_pkg::mbtb_regs_s s_reg;
	mbtb_pkg::mbtb_regs_s s_next;

	always_comb
	begin
		logic [31:0][7:0] rf;
		logic [15:0] ins;
		logic [15:0] nxt;
		logic [15:0] ptr;
		logic [4:0] rd;
		logic [4:0] rr;
		logic [4:0] pl;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] res;
		logic cout;
		logic vfl;
		logic upd;
		logic acc;
		logic acc_st;
		logic [4:0] acc_reg;
		logic [15:0] acc_addr;
		rf = s_reg.rf;
		ins = pm_rdata;
		nxt = s_reg.pc + 16'h0001;
		ptr = 16'h0000;
		rd = ins[8:4];
		rr = {ins[9], ins[3:0]};
		pl = mbtb_pkg::PTR_Z_LO;
		a = 8'h00;
		b = 8'h00;
		res = 8'h00;
		cout = 1'b0;
		vfl = 1'b0;
		upd = 1'b0;
		acc = 1'b0;
		acc_st = ins[9];
		acc_reg = rd;
		acc_addr = 16'h0000;
		s_next = s_reg;
		// pending load or in data lands before the next instruction reads it
		if (s_reg.wb_pend)
			rf[s_reg.wb_reg] = s_reg.wb_io ? io_rdata : dm_rdata;
		a = rf[rd];
		b = rf[rr];
		s_next.rf = rf;
		s_next.wb_pend = 1'b0;
		s_next.dm_we = 1'b0;
		s_next.dm_re = 1'b0;
		s_next.io_we = 1'b0;
		s_next.io_re = 1'b0;
		case (s_reg.state)
			mbtb_pkg::ST_EXEC:
			begin
				if (s_reg.run)
				begin
					s_next.pc = nxt;
					s_next.pm_addr = nxt;
					casez (ins)
						16'b1111_0???_????_????:
						begin
							if (ins[2:0] == mbtb_pkg::SIGNED_FLAG_SEL)
								cout = s_reg.status_register[mbtb_pkg::FLG_N] ^ s_reg.status_register[mbtb_pkg::FLG_V];
							else
								cout = s_reg.status_register[ins[2:0]];
							if (cout != ins[10])
							begin
								s_next.pc = nxt + {{9{ins[9]}}, ins[9:3]};
								s_next.pm_addr = nxt + {{9{ins[9]}}, ins[9:3]};
								s_next.state = mbtb_pkg::ST_STALL;
							end
						end
						16'b0010_11??_????_????:
							s_next.rf[rd] = b;
						16'b0000_0001_????_????:
						begin
							s_next.rf[{ins[7:4], 1'b0}] = rf[{ins[3:0], 1'b0}];
							s_next.rf[{ins[7:4], 1'b1}] = rf[{ins[3:0], 1'b1}];
						end
						16'b1110_????_????_????:
							s_next.rf[{1'b1, ins[7:4]}] = {ins[11:8], ins[3:0]};
						16'b000?_11??_????_????:
						begin
							// add, add with carry; shift left and rotate left are Rd=Rr
							{cout, res} = {1'b0, a} + {1'b0, b}
								+ {8'h00, ins[12] & s_reg.status_register[mbtb_pkg::FLG_C]};
							vfl = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
							s_next.status_register[mbtb_pkg::FLG_H] = (a[3] & b[3]) | (b[3] & ~res[3])
								| (~res[3] & a[3]);
							s_next.rf[rd] = res;
							upd = 1'b1;
						end
						16'b10?0_????_????_????:
						begin
							pl = ins[3] ? mbtb_pkg::PTR_Y_LO : mbtb_pkg::PTR_Z_LO;
							acc_addr = {rf[pl + 5'h01], rf[pl]}
								+ {10'h000, ins[13], ins[11:10], ins[2:0]};
							acc = 1'b1;
						end
						16'b1001_00??_????_0000:
						begin
							s_next.pc = s_reg.pc;
							s_next.tmp_reg = rd;
							s_next.tmp_flag = ins[9];
							s_next.state = mbtb_pkg::ST_WORD2;
						end
						16'b1001_000?_????_010?, 16'b1001_0101_1100_1000:
						begin
							ptr = {rf[mbtb_pkg::PTR_Z_LO + 5'h01], rf[mbtb_pkg::PTR_Z_LO]};
							s_next.pm_addr = {1'b0, ptr[15:1]};
							s_next.tmp_flag = ptr[0];
							s_next.tmp_reg = ins[10] ? 5'h00 : rd;
							if (ins[0] && !ins[10])
							begin
								ptr = ptr + 16'h0001;
								s_next.rf[mbtb_pkg::PTR_Z_LO] = ptr[7:0];
								s_next.rf[mbtb_pkg::PTR_Z_LO + 5'h01] = ptr[15:8];
							end
							s_next.state = mbtb_pkg::ST_LPM1;
						end
						16'b1001_00??_????_1111:
						begin
							acc = 1'b1;
							if (ins[9])
							begin
								acc_addr = s_reg.sp;
								s_next.sp = s_reg.sp - 16'h0001;
							end
							else
							begin
								acc_addr = s_reg.sp + 16'h0001;
								s_next.sp = s_reg.sp + 16'h0001;
							end
						end
						16'b1001_00??_????_????:
						begin
							pl = (ins[3:2] == 2'b11) ? mbtb_pkg::PTR_X_LO
								: (ins[3] ? mbtb_pkg::PTR_Y_LO : mbtb_pkg::PTR_Z_LO);
							ptr = {rf[pl + 5'h01], rf[pl]};
							if (ins[1:0] == 2'b10)
								ptr = ptr - 16'h0001;
							acc_addr = ptr;
							if (ins[1:0] == 2'b01)
								ptr = ptr + 16'h0001;
							s_next.rf[pl] = ptr[7:0];
							s_next.rf[pl + 5'h01] = ptr[15:8];
							acc = 1'b1;
						end
						16'b1011_0???_????_????:
						begin
							s_next.io_addr = {ins[10:9], ins[3:0]};
							s_next.io_re = 1'b1;
							s_next.wb_pend = 1'b1;
							s_next.wb_io = 1'b1;
							s_next.wb_reg = rd;
						end
						16'b1011_1???_????_????:
						begin
							s_next.io_addr = {ins[10:9], ins[3:0]};
							s_next.io_wdata = a;
							s_next.io_we = 1'b1;
						end
						16'b1001_10?0_????_????:
						begin
							s_next.io_addr = {1'b0, ins[7:3]};
							s_next.io_re = 1'b1;
							s_next.tmp_bit = ins[2:0];
							s_next.tmp_flag = ins[9];
							s_next.state = mbtb_pkg::ST_IOBIT;
						end
						16'b1001_010?_????_01??:
						begin
							cout = a[0];
							case (ins[1:0])
								2'b11: res = {s_reg.status_register[mbtb_pkg::FLG_C], a[7:1]};
								2'b01: res = {a[7], a[7:1]};
								default: res = {1'b0, a[7:1]};
							endcase
							vfl = res[7] ^ cout;
							s_next.rf[rd] = res;
							upd = 1'b1;
						end
						16'b1001_010?_????_0010:
							s_next.rf[rd] = {a[3:0], a[7:4]};
						16'b1001_0100_????_1000:
							s_next.status_register[ins[6:4]] = ~ins[7];
						16'b1111_101?_????_0???:
							s_next.status_register[mbtb_pkg::FLG_T] = a[ins[2:0]];
						16'b1111_100?_????_0???:
							s_next.rf[rd][ins[2:0]] = s_reg.status_register[mbtb_pkg::FLG_T];
						default:
							s_next.pc = nxt;
					endcase
				end
			end
			mbtb_pkg::ST_WORD2:
			begin
				acc = 1'b1;
				acc_st = s_reg.tmp_flag;
				acc_reg = s_reg.tmp_reg;
				acc_addr = pm_rdata;
				s_next.pc = s_reg.pc + 16'h0002;
				s_next.pm_addr = s_reg.pc + 16'h0002;
				s_next.state = mbtb_pkg::ST_EXEC;
			end
			mbtb_pkg::ST_LPM1:
			begin
				s_next.rf[s_reg.tmp_reg] = s_reg.tmp_flag ? pm_rdata[15:8] : pm_rdata[7:0];
				s_next.pm_addr = s_reg.pc;
				s_next.state = mbtb_pkg::ST_LPM2;
			end
			mbtb_pkg::ST_IOBIT:
			begin
				s_next.io_wdata = io_rdata;
				s_next.io_wdata[s_reg.tmp_bit] = s_reg.tmp_flag;
				s_next.io_we = 1'b1;
				s_next.state = mbtb_pkg::ST_EXEC;
			end
			default:
				s_next.state = mbtb_pkg::ST_EXEC;
		endcase
		if (upd)
		begin
			// shift and add flags
			s_next.status_register[mbtb_pkg::FLG_C] = cout;
			s_next.status_register[mbtb_pkg::FLG_Z] = (res == 8'h00);
			s_next.status_register[mbtb_pkg::FLG_N] = res[7];
			s_next.status_register[mbtb_pkg::FLG_V] = vfl;
			s_next.status_register[mbtb_pkg::FLG_S] = res[7] ^ vfl;
		end
		if (acc)
		begin
			s_next.dm_addr = acc_addr;
			if (s_reg.state == mbtb_pkg::ST_EXEC)
				s_next.state = mbtb_pkg::ST_STALL;
			if (acc_st)
			begin
				s_next.dm_wdata = rf[acc_reg];
				s_next.dm_we = 1'b1;
			end
			else
			begin
				s_next.dm_re = 1'b1;
				s_next.wb_pend = 1'b1;
				s_next.wb_io = 1'b0;
				s_next.wb_reg = acc_reg;
			end
		end
		// register bus slave, one access cycle
		s_next.pready = psel & ~penable;
		s_next.pslverr = 1'b0;
		if (psel && !penable)
		begin
			s_next.pslverr = 1'b0;
			case (paddr)
				mbtb_pkg::CTRL_OFS: s_next.prdata = {31'h00000000, s_reg.run};
				mbtb_pkg::STAT_OFS: s_next.prdata = {21'h000000, s_reg.state, s_reg.status_register};
				mbtb_pkg::PC_OFS: s_next.prdata = {16'h0000, s_reg.pc};
				mbtb_pkg::SP_OFS: s_next.prdata = {16'h0000, s_reg.sp};
				default:
				begin
					s_next.prdata = 32'h00000000;
					s_next.pslverr = 1'b1;
				end
			endcase
		end
		if (psel && penable && s_reg.pready && pwrite)
		begin
			if (paddr == mbtb_pkg::CTRL_OFS)
				s_next.run = pwdata[mbtb_pkg::CTRL_RUN_BIT];
			if (paddr == mbtb_pkg::SP_OFS)
				s_next.sp = pwdata[15:0];
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			s_reg <= '0;
			s_reg.sp <= SP_INIT;
			s_reg.run <= mbtb_pkg::CTRL_RUN_RESET;
		end
		else
			s_reg <= s_next;
	end

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign pm_addr = s_reg.pm_addr;
	assign dm_addr = s_reg.dm_addr;
	assign dm_wdata = s_reg.dm_wdata;
	assign dm_we = s_reg.dm_we;
	assign dm_re = s_reg.dm_re;
	assign io_addr = s_reg.io_addr;
	assign io_wdata = s_reg.io_wdata;
	assign io_we = s_reg.io_we;
	assign io_re = s_reg.io_re;
endmodule

// ===== verif/mbtb_mem.sv
// memory model: program words, data bytes, io registers
// assumes combinational reads at the core's registered addresses
`timescale 1ns/1ps
module mbtb_mem (
	input wire logic clock,
	input wire logic [15:0] pm_addr,
	output logic [15:0] pm_rdata,
	input wire logic [15:0] dm_addr,
	input wire logic [7:0] dm_wdata,
	input wire logic dm_we,
	input wire logic dm_re,
	output logic [7:0] dm_rdata,
	input wire logic [5:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic io_we,
	input wire logic io_re,
	output logic [7:0] io_rdata
);
	logic [15:0] pm [0:255];
	logic [7:0] dm [0:1023];
	logic [7:0] io [0:63];
	// unread data lines show inverted data
	assign pm_rdata = pm[pm_addr[7:0]];
	assign dm_rdata = dm_re ? dm[dm_addr[9:0]] : ~dm[dm_addr[9:0]];
	assign io_rdata = io_re ? io[io_addr] : ~io[io_addr];
	always @(posedge clock)
	begin
		if (dm_we)
			dm[dm_addr[9:0]] <= dm_wdata;
		if (io_we)
			io[io_addr] <= io_wdata;
	end
endmodule

// ===== verif/mbtb_core_chk.sv
// port checker for the core
// assumes bind onto mbtb_core, one clock domain
`timescale 1ns/1ps
module mbtb_core_chk (
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [15:0] pm_addr,
	input wire logic dm_we,
	input wire logic dm_re,
	input wire logic [5:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic io_we,
	input wire logic io_re,
	input wire logic [7:0] io_rdata
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_iobit; io_re ##1 io_we; endsequence
	property p_we; dm_we |=> !dm_we; endproperty
	a_we: assert property (p_we) else $error("store strobe too long");
	property p_re; dm_re |=> !dm_re; endproperty
	a_re: assert property (p_re) else $error("load strobe too long");
	property p_hold; (dm_we || dm_re) |=> $stable(pm_addr); endproperty
	a_hold: assert property (p_hold) else $error("fetch moved in stall");
	property p_ioad; s_iobit |-> io_addr == $past(io_addr); endproperty
	a_ioad: assert property (p_ioad) else $error("io address moved");
	property p_iobit; s_iobit |-> $countones(io_wdata ^ $past(io_rdata)) <= 1; endproperty
	a_iobit: assert property (p_iobit) else $error("io write alters other bits");
	property p_iolow; s_iobit |-> io_addr < 6'h20; endproperty
	a_iolow: assert property (p_iolow) else $error("io bit address range");
	property p_ans; psel && !penable |=> pready ##1 !pready; endproperty
	a_ans: assert property (p_ans) else $error("apb answer timing");
	property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("apb error form");
	c_st: cover property (dm_we);
	c_ld: cover property (dm_re);
	c_io: cover property (s_iobit);
	c_err: cover property (pslverr);
endmodule
bind mbtb_core mbtb_core_chk mbtb_core_chk_i (.clock(clock), .rst(rst), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pm_addr(pm_addr), .dm_we(dm_we), .dm_re(dm_re), .io_addr(io_addr),
	.io_wdata(io_wdata), .io_we(io_we), .io_re(io_re), .io_rdata(io_rdata));

// ===== verif/tb_top.sv
// bench: random program run against a flag, store and cycle model
// assumes mbtb_mem as memory and the bound checker
`timescale 1ns/1ps
module tb_top;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, seed, r;
	logic pready, pslverr, dm_we, dm_re, io_we, io_re, cond, taken;
	logic [15:0] pm_addr, pm_rdata, dm_addr;
	logic [7:0] dm_wdata, dm_rdata, io_wdata, io_rdata, status_register, v, last, io_init;
	logic [5:0] io_addr;
	logic [2:0] f;
	logic [32:0] q;
	logic [23:0] exp_st[$], got_st[$];
	int miscompares = 0, check_count = 0, cyc = 0, cyc_seen = 0, pcw = 0, x = 96, n;
	int end_pc = 0;
	always #25 clock = ~clock;
	mbtb_core mbtb_core_i (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm_addr(dm_addr),
		.dm_wdata(dm_wdata), .dm_we(dm_we), .dm_re(dm_re), .dm_rdata(dm_rdata),
		.io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re),
		.io_rdata(io_rdata));
	mbtb_mem mbtb_mem_i (.clock(clock), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
		.dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_re(dm_re),
		.dm_rdata(dm_rdata), .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we),
		.io_re(io_re), .io_rdata(io_rdata));
	always @(negedge clock)
	begin
		if (dm_we === 1'b1)
			got_st.push_back({dm_addr, dm_wdata});
		if (!rst && pm_addr !== end_pc[15:0])
			cyc_seen++;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic emit(input logic [15:0] w, input int cy);
		mbtb_mem_i.pm[pcw] = w;
		pcw++;
		cyc += cy;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a);
		int k = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= r;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1 && k < 20)
		begin
			@(posedge clock);
			k++;
		end
		q = {pslverr, prdata};
		check("apb wait", k < 20, 1'b1);
		if (k == 20)
			print_verdict();
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	initial
	begin
		seed = 32'd86;
		foreach (mbtb_mem_i.pm[i])
			mbtb_mem_i.pm[i] = 16'h0000;
		foreach (mbtb_mem_i.dm[i])
			mbtb_mem_i.dm[i] = 8'h00;
		r = xs();
		mbtb_mem_i.io[5] = r[7:0];
		io_init = r[7:0];
		status_register = 8'h00;
		last = 8'h00;
		emit(16'hE6A0, 1);
		emit(16'hE0B0, 1);
		for (int s = 0; s < 16; s++)
		begin
			r = xs();
			v = r[7:0];
			f = 3'(s >> 1);
			emit({4'hE, v[7:4], 4'h0, v[3:0]}, 1);
			emit(16'h1F00, 1);
			cond = status_register[0];
			status_register[0] = v[7];
			status_register[5] = v[3];
			v = {v[6:0], cond};
			status_register[1] = (v == 8'h00);
			status_register[2] = v[7];
			status_register[3] = v[7] ^ status_register[0];
			status_register[4] = status_register[2] ^ status_register[3];
			emit({8'h94, ~r[8], f, 4'h8}, 1);
			status_register[f] = r[8];
			cond = (f == 3'h4) ? status_register[2] ^ status_register[3] : status_register[f];
			taken = cond ^ s[0];
			emit({5'h1E, s[0], 7'h01, f}, taken ? 2 : 1);
			emit(16'h930D, taken ? 0 : 2);
			if (!taken)
			begin
				exp_st.push_back({x[15:0], v});
				last = v;
				x++;
			end
		end
		emit(16'h911E, 2);
		emit(16'h931F, 2);
		exp_st.push_back({mbtb_pkg::SP_RESET, last});
		emit(16'h9A2B, 2);
		emit(16'h9468, 1);
		status_register[6] = 1'b1;
		end_pc = pcw;
		emit(16'hF3FE, 0);
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		apb(1'b0, mbtb_pkg::CTRL_OFS);
		check("ctrl", q, {32'h0, mbtb_pkg::CTRL_RUN_RESET});
		apb(1'b0, mbtb_pkg::SP_OFS);
		check("sp", q, {17'h0, mbtb_pkg::SP_RESET});
		apb(1'b1, 8'h10);
		check("unmapped", q, 33'h100000000);
		$display("register test done");
		n = 0;
		while (pm_addr !== end_pc[15:0] && n < 500)
		begin
			@(negedge clock);
			n++;
		end
		check("program end", n < 500, 1'b1);
		repeat (4) @(negedge clock);
		check("cycles", cyc_seen, cyc);
		check("store count", got_st.size(), exp_st.size());
		foreach (exp_st[i])
			check("store", got_st[i], exp_st[i]);
		check("io bit", mbtb_mem_i.io[5], io_init | 8'h08);
		apb(1'b0, mbtb_pkg::PC_OFS);
		check("pc", q, 33'(end_pc));
		apb(1'b0, mbtb_pkg::STAT_OFS);
		check("flags", q[7:0], status_register);
		apb(1'b0, mbtb_pkg::SP_OFS);
		check("sp push", q, {17'h0, mbtb_pkg::SP_RESET - 16'h1});
		$display("program test done");
		print_verdict();
	end
endmodule
